// ---- testbench/aosd_far_side.sv ----
// Far-side model: servo loop, encoder marker, origin switch, safety pins.
// Assumes the block's pclk domain; marker and switch follow demand.
`timescale 1ns/1ps
module aosd_far_side #(
    parameter int SW_IN = 12                 // Input wired to the switch
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // Bench controls
    input  wire logic [3:0]            ferr_kick,
    input  wire logic                  brk,
    // Motion seen from the block
    input  wire logic                  mv_active,
    input  wire logic [1:0]            mv_axis,
    input  wire logic [3:0][31:0]      dem_pos,
    // Servo, encoder and pins
    output logic                       servo_tick,
    output logic [11:0]                servo_calc,
    output logic [3:0][31:0]           meas_raw,
    output logic [3:0]                 ferr_evt,
    output logic [3:0]                 z_marker_pin,
    output logic [31:0]                din_pin,
    output aosd_pkg::aosd_pins_t       safety_pins
);
    logic [2:0]         tick_cnt;      // Servo period divider
    logic signed [31:0] pos;           // Demand of the searched axis
    logic               sw_set;        // Switch reached
    // Tick every eight clocks, slow enough for the pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 3'h0;
            servo_tick <= 1'b0;
            ferr_evt <= 4'h0;
        end else begin
            tick_cnt <= tick_cnt + 3'h1;
            servo_tick <= (tick_cnt == 3'h7);
            ferr_evt <= ferr_kick;
        end
    end
    // Marker every 32 counts, switch at 64 counts or more either way
    always_comb begin
        pos = dem_pos[mv_axis];
        sw_set = (pos >= 32'sh40) || (pos <= -32'sh40);
        servo_calc = 12'h123;
        z_marker_pin = 4'h0;
        if (mv_active && pos[4:0] == 5'h05) begin
            z_marker_pin[mv_axis] = 1'b1;
        end
        for (int i = 0; i < 4; i++) begin
            meas_raw[i] = 32'((i + 1) * 256);
        end
        din_pin = 32'hFFFFFFFF;
        din_pin[SW_IN] = ~sw_set;
        safety_pins = brk ? 5'h00 : 5'h1F;
    end
endmodule

// ---- testbench/axis_origin_search_and_drive_output_tb.sv ----
// Self-checking bench for the origin search and drive selector.
// Assumes the far-side model supplies ticks, marker and switch.
`timescale 1ns/1ps
module axis_origin_search_and_drive_output_tb;
    logic                       pclk, presetn, brk, servo_tick, busy;
    logic                       pready, pslverr, mv_active, mv_dir;
    aosd_pkg::aosd_apb_t        apb;
    aosd_pkg::aosd_pins_t       safety_pins;
    logic [31:0]                prdata, din_pin, rd;
    logic [11:0]                servo_calc, drive_out;
    logic [3:0][31:0]           meas_raw, dem_pos;
    logic [3:0]                 ferr_evt, z_marker_pin, ferr_kick;
    logic [1:0]                 mv_axis;
    logic                       err;
    int                         n_mismatch, checked;
    logic signed [31:0]         exp_off [4];   // Expected position offsets
    logic signed [31:0]         olds [6] = '{32'sh5, -32'sh1B, 32'sh3F,
                                             -32'sh3F, 32'sh25, -32'sh3B};

    aosd_axis_origin uut (.pclk(pclk), .presetn(presetn), .apb(apb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .servo_tick(servo_tick), .servo_calc(servo_calc),
        .meas_raw(meas_raw), .ferr_evt(ferr_evt),
        .z_marker_pin(z_marker_pin), .din_pin(din_pin),
        .safety_pins(safety_pins), .drive_out(drive_out),
        .mv_active(mv_active), .mv_dir(mv_dir), .mv_axis(mv_axis),
        .dem_pos(dem_pos), .busy(busy));
    aosd_far_side far (.pclk(pclk), .presetn(presetn),
        .ferr_kick(ferr_kick), .brk(brk), .mv_active(mv_active),
        .mv_axis(mv_axis), .dem_pos(dem_pos), .servo_tick(servo_tick),
        .servo_calc(servo_calc), .meas_raw(meas_raw), .ferr_evt(ferr_evt),
        .z_marker_pin(z_marker_pin), .din_pin(din_pin),
        .safety_pins(safety_pins));

    // Verdict and end of run
    task automatic wrap_up();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; the wait for pready is bounded
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        int n;
        @(posedge pclk);
        apb <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
        @(posedge pclk);
        apb.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk("read data", rd, exp);
    endtask
    // Drive one clock later, then look at the output
    task automatic drv_chk(input logic [11:0] exp);
        @(posedge pclk);
        #1;
        chk("drive_out", 32'(drive_out), 32'(exp));
    endtask
    // Start a search and check the first leg's direction and axis
    task automatic start_seq(input logic [2:0] sel, input logic ovr,
                             input logic [1:0] ax);
        wr(aosd_pkg::A_CMD, {25'h0, ax, ovr, 1'b0, sel});
        @(posedge pclk);
        #1;
        chk("mv_dir", 32'(mv_dir), 32'(sel[0]));
        chk("mv_axis", 32'(mv_axis), 32'(ax));
        chk("mv_active", 32'(mv_active), 32'h1);
    endtask
    // Wait for re-zero, then check demand and, on axis 0 only, corrected position
    task automatic finish_seq(input logic [1:0] ax,
                              input logic signed [31:0] old);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (n >= 3000) begin
            n_mismatch++;
            wrap_up();
        end
        chk("dem_pos", dem_pos[ax], 32'h0);
        chk("mv_active", 32'(mv_active), 32'h0);
        exp_off[ax] = exp_off[ax] - old;
        if (ax == 2'h0) begin
            rdchk(aosd_pkg::A_MPOS, 32'h100 + exp_off[0]);
        end
    endtask

    // Drive source, clamp and readback
    task automatic t_drive();
        rdchk(aosd_pkg::A_OLIM, 32'h7FF);
        wr(aosd_pkg::A_OLDRV, 32'hFFF);
        drv_chk(12'hFFF);
        rdchk(aosd_pkg::A_APPL, 32'hFFFFFFFF);
        wr(aosd_pkg::A_OLIM, 32'h100);
        wr(aosd_pkg::A_OLDRV, 32'h7FF);
        drv_chk(12'h100);
        wr(aosd_pkg::A_OLDRV, 32'h800);
        drv_chk(12'hEFF);
        rdchk(aosd_pkg::A_APPL, 32'hFFFFFEFF);
        wr(aosd_pkg::A_CTRL, 32'h1);
        drv_chk(12'h123);
        rdchk(aosd_pkg::A_APPL, 32'h123);
        wr(aosd_pkg::A_CTRL, 32'h0);
        wr(aosd_pkg::A_OLIM, 32'h7FF);
    endtask
    // Unmapped address and active-low pins
    task automatic t_regs();
        xfer(8'h2C, 1'b0, 32'h0);
        chk("pslverr", 32'(err), 32'h1);
        chk("unmapped data", rd, 32'h0);
        brk <= 1'b1;
        repeat (4) @(posedge pclk);
        xfer(aosd_pkg::A_STAT, 1'b0, 32'h0);
        chk("pins", 32'(rd[12:8]), 32'h1F);
        brk <= 1'b0;
    endtask
    // Switch select range and refused commands
    task automatic t_osel();
        wr(aosd_pkg::A_OSEL, 32'hC);
        wr(aosd_pkg::A_OSEL, 32'h10);
        rdchk(aosd_pkg::A_OSEL, 32'hC);
        wr(aosd_pkg::A_OSEL, 32'hFFFFFFFF);
        rdchk(aosd_pkg::A_OSEL, 32'hFFFFFFFF);
        wr(aosd_pkg::A_CMD, 32'h3);
        xfer(aosd_pkg::A_STAT, 1'b0, 32'h0);
        chk("no switch", 32'(rd[3:0]), 32'h8);
        wr(aosd_pkg::A_OSEL, 32'hC);
        wr(aosd_pkg::A_CMD, 32'h7);
        xfer(aosd_pkg::A_STAT, 1'b0, 32'h0);
        chk("bad selector", 32'(rd[3:0]), 32'h8);
    endtask
    // Refusal while busy
    task automatic t_busy();
        start_seq(3'h2, 1'b0, 2'h0);
        wr(aosd_pkg::A_CMD, 32'h1);
        xfer(aosd_pkg::A_STAT, 1'b0, 32'h0);
        chk("busy reject", 32'(rd[3:0]), 32'hD);
        finish_seq(2'h0, olds[1]);
    endtask
    // Following error clear and demand copy
    task automatic t_zero();
        ferr_kick <= 4'h2;
        @(posedge pclk);
        ferr_kick <= 4'h0;
        xfer(aosd_pkg::A_STAT, 1'b0, 32'h0);
        chk("ferr set", 32'(rd[7:4]), 32'h2);
        wr(aosd_pkg::A_CMD, 32'h0);
        xfer(aosd_pkg::A_STAT, 1'b0, 32'h0);
        chk("ferr clear", 32'(rd[7:4]), 32'h0);
        for (int i = 0; i < 4; i++) begin
            chk("copy", dem_pos[i], 32'((i + 1) * 256) + exp_off[i]);
        end
    endtask

    // Free-running clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Main sequence
    initial begin
        presetn = 1'b0;
        apb = '0;
        ferr_kick = 4'h0;
        brk = 1'b0;
        n_mismatch = 0;
        checked = 0;
        for (int i = 0; i < 4; i++) begin
            exp_off[i] = 32'sh0;
        end
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_drive();
        t_regs();
        t_osel();
        for (int s = 1; s <= 6; s++) begin
            start_seq(3'(s), 1'b0, 2'h0);
            finish_seq(2'h0, olds[s - 1]);
        end
        start_seq(3'h1, 1'b1, 2'h2);
        finish_seq(2'h2, olds[0]);
        t_busy();
        t_zero();
        wrap_up();
    end
endmodule

// ---- verilog/aosd_axis_origin.sv ----
// Origin search sequencer and drive source selector for four axes.
// Assumes an APB master on pclk, a servo tick strobe and servo result
// on pclk, and asynchronous pins for markers, switches and limits.
// Notes on behaviour
// - Servo off: drive the open-loop value
// - Servo on: drive the servo result
// - Applied drive value is readable back
// - Readback is signed, -2048 to 2047
// - Search command uses creep and demand speed
// - Switch sequences use selected input number
// - Default axis unless command overrides it
// - Sequence 0: demand=measured, clear errors
// - Sequence 1: creep forward to marker
// - Sequence 2: creep reverse to marker
// - Sequence 3: fast fwd, creep back off
// - Sequence 4: fast rev, creep back off
// - Sequence 5: fast fwd, creep rev to marker
// - Sequence 6: fast rev, creep fwd to marker
// - Re-zero demand, keep following error
// - Origin switch input is active low
// - Hold, jog and limit pins active low
// - Switch select 0-15, 20-31, or -1
// - Output limit bounds the open-loop value
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module aosd_axis_origin (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire aosd_pkg::aosd_apb_t   apb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Servo loop, same clock
    input  wire logic                  servo_tick,
    input  wire logic [11:0]           servo_calc,
    input  wire logic [aosd_pkg::NAX-1:0][31:0] meas_raw,
    input  wire logic [aosd_pkg::NAX-1:0] ferr_evt,
    // Asynchronous pins
    input  wire logic [aosd_pkg::NAX-1:0] z_marker_pin,
    input  wire logic [aosd_pkg::NIN-1:0] din_pin,
    input  wire aosd_pkg::aosd_pins_t  safety_pins,
    // Drive and motion
    output logic [11:0]                drive_out,
    output logic                       mv_active,
    output logic                       mv_dir,
    output logic [aosd_pkg::AXW-1:0]   mv_axis,
    output logic [aosd_pkg::NAX-1:0][31:0] dem_pos,
    output logic                       busy
);
    aosd_pkg::aosd_state_t s;          // Registered state
    aosd_pkg::aosd_state_t n;          // Next state
    logic [31:0]           rd;         // Read mux
    logic [11:0]           olc;        // Clamped open-loop value
    logic                  sw_set;     // Origin switch seen set
    logic                  z_hit;      // Marker on active axis
    logic                  hit;        // Awaited event this tick
    logic                  setup;      // APB setup cycle
    logic                  wr_go;      // APB write takes effect
    logic [15:0]           sp;         // Current segment speed
    logic [31:0]           fe_ax;      // Following error, axis
    // Accepts input numbers 0-15 and 20-31 only
    function automatic logic sw_ok(input logic [5:0] v);
        sw_ok = (v <= aosd_pkg::IN_LO_MAX) ||
                (v >= aosd_pkg::IN_HI_MIN && v <= aosd_pkg::IN_HI_MAX);
    endfunction
    // Measured position as seen after re-zero shifts
    function automatic logic [31:0] meas_of(input logic [31:0] raw,
                                            input logic [31:0] off);
        meas_of = raw + off;
    endfunction
    // Decoded register space
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= aosd_pkg::A_MPOS);
    endfunction
    assign setup = apb.psel & ~apb.penable;
    assign wr_go = apb.psel & apb.penable & s.pready & apb.pwrite;
    assign fe_ax = s.dem[s.ax] - meas_of(meas_raw[s.ax], s.offs[s.ax]);
    always_comb begin
        if ($signed(s.oldrv) > $signed({1'b0, s.olim}))
            olc = {1'b0, s.olim};
        else if ($signed(s.oldrv) < -$signed({1'b0, s.olim}) - 12'sh001)
            olc = 12'h000 - {1'b0, s.olim} - 12'h001;
        else
            olc = s.oldrv;
    end
    always_comb begin
        sw_set = sw_ok(s.osel) && !s.ds2[s.osel[4:0]];
        z_hit  = s.zs2[s.ax];
        // Switch clear ends 3, 4 creep
        if (s.st == aosd_pkg::ST_FAST)
            hit = sw_set;
        else if (s.seq == 3'h3 || s.seq == 3'h4)
            hit = !sw_set;
        else
            hit = z_hit;
        sp = (s.st == aosd_pkg::ST_FAST) ? s.spd : s.creep;
    end
    // Register read mux, upper bits zero or sign-extended
    always_comb begin
        rd = 32'h0000_0000;
        if (apb.paddr == aosd_pkg::A_CTRL) begin
            rd = {29'h0, s.dax, s.clen};
        end else if (apb.paddr == aosd_pkg::A_OLDRV) begin
            rd = {{20{s.oldrv[11]}}, s.oldrv};
        end else if (apb.paddr == aosd_pkg::A_CREEP) begin
            rd = {16'h0000, s.creep};
        end else if (apb.paddr == aosd_pkg::A_SPEED) begin
            rd = {16'h0000, s.spd};
        end else if (apb.paddr == aosd_pkg::A_OSEL) begin
            rd = {{26{s.osel[5]}}, s.osel};
        end else if (apb.paddr == aosd_pkg::A_OLIM) begin
            rd = {21'h0, s.olim};
        end else if (apb.paddr == aosd_pkg::A_CMD) begin
            rd = {27'h0, s.ax, s.seq};
        end else if (apb.paddr == aosd_pkg::A_STAT) begin
            rd = {19'h0, ~s.ps2, s.ferr, s.rej, s.st, s.busy};
        end else if (apb.paddr == aosd_pkg::A_APPL) begin
            rd = {{20{s.drv[11]}}, s.drv};
        end else if (apb.paddr == aosd_pkg::A_DPOS) begin
            rd = s.dem[s.dax];
        end else if (apb.paddr == aosd_pkg::A_MPOS) begin
            rd = meas_of(meas_raw[s.dax], s.offs[s.dax]);
        end
    end
    // Next-state logic of the whole block
    always_comb begin
        n = s;
        // Two flops on every pin, first flop feeds only the second
        n.zs1 = z_marker_pin;
        n.zs2 = s.zs1;
        n.ds1 = din_pin;
        n.ds2 = s.ds1;
        n.ps1 = safety_pins;
        n.ps2 = s.ps1;
        n.drv = s.clen ? servo_calc : olc;
        // Zero-wait answer: ready in first access cycle
        n.pready = setup;
        if (setup) begin
            n.prdata  = rd;
            n.pslverr = !mapped(apb.paddr);
        end
        // Sequencer, events taken on servo ticks only
        case (s.st)
            aosd_pkg::ST_FAST, aosd_pkg::ST_CREEP: begin
                if (servo_tick && hit) begin
                    if (s.st == aosd_pkg::ST_FAST) begin
                        n.st  = aosd_pkg::ST_CREEP;
                        n.dir = ~s.dir;
                    end else begin
                        n.st = aosd_pkg::ST_REZERO;
                        n.mv = 1'b0;
                    end
                end else if (servo_tick && s.ps2.feedhold_n) begin
                    // Demand advances unless feedhold pulls low
                    n.dem[s.ax] = s.dir ? s.dem[s.ax] + {16'h0000, sp}
                                        : s.dem[s.ax] - {16'h0000, sp};
                end
            end
            aosd_pkg::ST_REZERO: begin
                n.offs[s.ax] = s.offs[s.ax] - s.dem[s.ax];
                n.dem[s.ax]  = 32'h0000_0000;
                n.st         = aosd_pkg::ST_IDLE;
                n.busy       = 1'b0;
            end
            default: begin
            end
        endcase
        // Register writes
        if (wr_go) begin
            if (apb.paddr == aosd_pkg::A_CTRL) begin
                n.clen = apb.pwdata[0];
                n.dax  = apb.pwdata[aosd_pkg::CTRL_AX +: aosd_pkg::AXW];
            end else if (apb.paddr == aosd_pkg::A_OLDRV) begin
                n.oldrv = apb.pwdata[11:0];
            end else if (apb.paddr == aosd_pkg::A_CREEP) begin
                n.creep = apb.pwdata[15:0];
            end else if (apb.paddr == aosd_pkg::A_SPEED) begin
                n.spd = apb.pwdata[15:0];
            end else if (apb.paddr == aosd_pkg::A_OSEL) begin
                if (sw_ok(apb.pwdata[5:0]) ||
                    apb.pwdata[5:0] == aosd_pkg::OSEL_NONE)
                    n.osel = apb.pwdata[5:0];
            end else if (apb.paddr == aosd_pkg::A_OLIM) begin
                n.olim = apb.pwdata[10:0];
            end else if (apb.paddr == aosd_pkg::A_CMD) begin
                if (s.busy) begin
                    n.rej = 1'b1;
                end else if (apb.pwdata[2:0] == 3'h0) begin
                    for (int i = 0; i < aosd_pkg::NAX; i++)
                        n.dem[i] = meas_of(meas_raw[i], s.offs[i]);
                    n.ferr = '0;
                    n.rej  = 1'b0;
                end else if (apb.pwdata[2:0] == aosd_pkg::SEQ_BAD ||
                             (apb.pwdata[2:0] >= aosd_pkg::SEQ_SW &&
                              !sw_ok(s.osel))) begin
                    // Selector 7 undefined, or no switch chosen so search cannot finish
                    n.rej = 1'b1;
                end else begin
                    n.ax = apb.pwdata[aosd_pkg::CMD_OVR]
                         ? apb.pwdata[aosd_pkg::CMD_AX +: aosd_pkg::AXW]
                         : s.dax;
                    n.seq  = apb.pwdata[2:0];
                    n.dir  = apb.pwdata[0];
                    // Switch sequences start fast
                    // Marker-only ones creep first
                    n.st   = (apb.pwdata[2:0] < aosd_pkg::SEQ_SW)
                           ? aosd_pkg::ST_CREEP : aosd_pkg::ST_FAST;
                    n.mv   = 1'b1;
                    n.busy = 1'b1;
                    n.rej  = 1'b0;
                end
            end
        end
        // Error events set after clears, so a set wins
        n.ferr = n.ferr | ferr_evt;
    end
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s       <= '0;
            s.st    <= aosd_pkg::ST_IDLE;
            s.olim  <= aosd_pkg::OLIM_RST;
            s.osel  <= aosd_pkg::OSEL_NONE;
            s.creep <= aosd_pkg::CREEP_RST;
            s.spd   <= aosd_pkg::SPEED_RST;
            s.ps1   <= '1;
            s.ps2   <= '1;
            s.ds1   <= '1;
            s.ds2   <= '1;
        end else begin
            s <= n;
        end
    end
    // Outputs straight from state flops
    assign prdata    = s.prdata;
    assign pready    = s.pready;
    assign pslverr   = s.pslverr;
    assign drive_out = s.drv;
    assign mv_active = s.mv;
    assign mv_dir    = s.dir;
    assign mv_axis   = s.ax;
    assign dem_pos   = s.dem;
    assign busy      = s.busy;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Event awaited on a tick
    sequence s_tick_hit;
        servo_tick && hit;
    endsequence
    // Command write accepted at the access edge
    sequence s_cmd;
        wr_go && apb.paddr == aosd_pkg::A_CMD && !s.busy;
    endsequence
    property p_open;
        !s.clen |=> drive_out == $past(olc);
    endproperty
    a_open: assert property (p_open)
        else $error("open-loop value not driven");
    property p_closed;
        s.clen |=> drive_out == $past(servo_calc);
    endproperty
    a_closed: assert property (p_closed)
        else $error("servo result not driven");
    property p_readback;
        setup && apb.paddr == aosd_pkg::A_APPL |=>
            prdata == {{20{$past(drive_out[11])}}, $past(drive_out)};
    endproperty
    a_readback: assert property (p_readback)
        else $error("applied drive readback wrong");
    property p_limit;
        !s.clen |=> $signed(drive_out) <= $signed({1'b0, $past(s.olim)}) &&
            $signed(drive_out) >= -$signed({1'b0, $past(s.olim)}) - 12'sh001;
    endproperty
    a_limit: assert property (p_limit)
        else $error("open-loop drive outside limit");
    property p_reject;
        s.busy && wr_go && apb.paddr == aosd_pkg::A_CMD |=>
            s.rej && $stable(s.seq) && $stable(s.ax);
    endproperty
    a_reject: assert property (p_reject)
        else $error("command taken while busy");
    property p_datum0;
        s_cmd ##0 apb.pwdata[2:0] == 3'h0 |=>
            s.ferr == $past(ferr_evt) && !s.busy;
    endproperty
    a_datum0: assert property (p_datum0)
        else $error("errors not cleared by sequence 0");
    property p_rezero;
        s.st == aosd_pkg::ST_REZERO |=>
            s.dem[$past(s.ax)] == 32'h0 && fe_ax == $past(fe_ax)
            && !busy;
    endproperty
    a_rezero: assert property (p_rezero)
        else $error("re-zero lost following error");
    property p_fast_end;
        s.st == aosd_pkg::ST_FAST ##0 s_tick_hit |=>
            s.st == aosd_pkg::ST_CREEP && mv_dir != $past(mv_dir);
    endproperty
    a_fast_end: assert property (p_fast_end)
        else $error("fast leg did not turn to creep");
    property p_creep_end;
        s.st == aosd_pkg::ST_CREEP ##0 s_tick_hit |=>
            s.st == aosd_pkg::ST_REZERO ##1 s.st == aosd_pkg::ST_IDLE;
    endproperty
    a_creep_end: assert property (p_creep_end)
        else $error("creep leg did not end on event");
    property p_start_dir;
        s_cmd ##0 apb.pwdata[2:0] != 3'h0 &&
        apb.pwdata[2:0] != aosd_pkg::SEQ_BAD && sw_ok(s.osel) |=>
            busy && mv_dir == $past(apb.pwdata[0]);
    endproperty
    a_start_dir: assert property (p_start_dir)
        else $error("search started wrong way");
endmodule

// ---- verilog/aosd_pkg.sv ----
// Constants, carriers and state type of the axis origin search block.
// Assumes one 40 MHz APB clock and a servo tick from the same domain.
package aosd_pkg;
    localparam int NAX = 4;                    // Axes served
    localparam int AXW = 2;                    // Axis index width
    localparam int NIN = 32;                   // Digital input count
    // Register byte offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_OLDRV = 8'h04;
    localparam logic [7:0] A_CREEP = 8'h08;
    localparam logic [7:0] A_SPEED = 8'h0C;
    localparam logic [7:0] A_OSEL  = 8'h10;
    localparam logic [7:0] A_OLIM  = 8'h14;
    localparam logic [7:0] A_CMD   = 8'h18;
    localparam logic [7:0] A_STAT  = 8'h1C;
    localparam logic [7:0] A_APPL  = 8'h20;
    localparam logic [7:0] A_DPOS  = 8'h24;
    localparam logic [7:0] A_MPOS  = 8'h28;
    // Field positions
    localparam int CTRL_AX = 1;                // Default axis field
    localparam int CMD_OVR = 4;                // Axis override flag
    localparam int CMD_AX  = 5;                // Override axis field
    // Values after reset
    localparam logic [10:0] OLIM_RST  = 11'h7FF;
    localparam logic [5:0]  OSEL_NONE = 6'h3F; // Minus one: no switch
    localparam logic [15:0] CREEP_RST = 16'h0001;
    localparam logic [15:0] SPEED_RST = 16'h0010;
    // Valid switch input numbers
    localparam logic [5:0] IN_LO_MAX = 6'h0F;
    localparam logic [5:0] IN_HI_MIN = 6'h14;
    localparam logic [5:0] IN_HI_MAX = 6'h1F;
    // Sequence selectors
    localparam logic [2:0] SEQ_SW  = 3'h3;     // First switch sequence
    localparam logic [2:0] SEQ_BAD = 3'h7;     // Not defined
    typedef enum logic [1:0] {
        ST_IDLE, ST_FAST, ST_CREEP, ST_REZERO
    } aosd_st_t;
    // APB request from the master
    typedef struct packed {
        logic [7:0]  paddr;
        logic        pwrite;
        logic [31:0] pwdata;
        logic        psel;
        logic        penable;
    } aosd_apb_t;
    // Active-low safety pins
    typedef struct packed {
        logic feedhold_n;
        logic jog_fwd_n;
        logic jog_rev_n;
        logic lim_fwd_n;
        logic lim_rev_n;
    } aosd_pins_t;
    // Whole state of the block
    typedef struct packed {
        logic                      clen;
        logic [AXW-1:0]            dax;
        logic [11:0]               oldrv;
        logic [15:0]               creep;
        logic [15:0]               spd;
        logic [5:0]                osel;
        logic [10:0]               olim;
        logic [11:0]               drv;
        aosd_st_t                  st;
        logic [2:0]                seq;
        logic [AXW-1:0]            ax;
        logic                      dir;
        logic                      mv;
        logic                      busy;
        logic                      rej;
        logic [NAX-1:0][31:0]      dem;
        logic [NAX-1:0][31:0]      offs;
        logic [NAX-1:0]            ferr;
        logic [NAX-1:0]            zs1;
        logic [NAX-1:0]            zs2;
        logic [NIN-1:0]            ds1;
        logic [NIN-1:0]            ds2;
        aosd_pins_t                ps1;
        aosd_pins_t                ps2;
        logic [31:0]               prdata;
        logic                      pready;
        logic                      pslverr;
    } aosd_state_t;
endpackage
